// ### hw/ood_decoder.sv
`timescale 1ns/1ps
// Behaviour
// - Access bit selects access RAM or bank
// - Destination bit picks accumulator or file
// - Three-bit field selects one bit
// - File field is 8-bit address or pointer
// - Moves carry two 12-bit unbanked addresses
// - Fast bit saves or restores shadow registers
// - Table ops carry four pointer update modes
// - Table pointer 21 bits, latch 8 bits
// - Branch operand relative or absolute target
// - Literals are 8, 12 or 20 bits
// - Indexed moves use a 7-bit source offset and a 7-bit offset or 12-bit address as destination
// - Don't-care bits never affect decode
// - Lone second word executes as no-op
// - Instruction cycle spans four oscillator periods
module ood_decoder
   import ood_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        srst,
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   output logic             dec_strobe,
   output logic      [11:0] data_address,
   output logic             result_to_file,
   output logic      [7:0]  bit_select,
   output logic      [1:0]  pointer_select,
   output logic      [19:0] literal_value,
   output logic      [19:0] branch_value,
   output logic             branch_relative,
   output logic             shadow_save,
   output logic             shadow_restore,
   output logic      [11:0] move_src,
   output logic      [11:0] move_dst,
   output logic      [6:0]  src_offset,
   output logic      [6:0]  dst_offset,
   output logic      [20:0] table_address,
   output logic      [1:0]  exec_cycles
);
   logic [1:0]            phase;
   logic                  icyc_end;
   logic [BANK_W-1:0]     bank_selector_register;
   logic [TP_W-1:0]       table_pointer;
   logic [TL_W-1:0]       table_latch;
   logic                  pending;
   logic                  pair_err;
   logic [15:0]           first_word;
   logic [15:0]           word_q;
   ood_fmt_e              fmt_q;
   logic                  req;
   logic                  accept;
   logic                  instr_wr;
   logic [15:0]           w;
   ood_fmt_e              next_fmt;
   logic                  next_pend;
   logic                  next_err;
   logic [11:0]           next_addr;
   logic                  next_tofile;
   logic [19:0]           next_lit;
   logic [19:0]           next_br;
   logic                  next_rel;
   logic                  next_save;
   logic                  next_restore;
   logic [11:0]           next_src;
   logic [11:0]           next_dst;
   logic [6:0]            next_soff;
   logic [6:0]            next_doff;
   logic [1:0]            next_cyc;
   logic                  next_bankld;
   ood_tpmode_e           next_mode;

   // Access RAM splits at 80h: low half is GPR, high half the top bank
   function automatic logic [11:0] file_addr(input logic [7:0] f, input logic a,
                                             input logic [BANK_W-1:0] bank);
      if (a)
         file_addr = {bank, f};
      else
         file_addr = {(f[7] ? ACC_HI_BANK : 4'h0), f};
   endfunction

   function automatic logic [19:0] sext(input logic [10:0] n, input logic wide);
      sext = wide ? {{9{n[10]}}, n} : {{12{n[7]}}, n[7:0]};
   endfunction

   // Instruction cycle divider
   always_ff @(posedge core_clk) begin
      if (srst)
         phase <= 2'h0;
      else
         phase <= phase + 2'h1;
   end
   assign icyc_end = (phase == 2'(OSC_PER_ICYC - 1));

   assign req      = avs_read | avs_write;
   assign instr_wr = avs_write && avs_address == OFF_INSTR;
   assign accept   = req && avs_waitrequest && (!instr_wr || icyc_end);
   assign w        = avs_writedata[15:0];

   // Field decode of the word being written
   always_comb begin
      next_fmt     = F_OTHER;
      next_pend    = 1'b0;
      next_err     = 1'b0;
      next_addr    = data_address;
      next_tofile  = 1'b0;
      next_lit     = 20'h00000;
      next_br      = 20'h00000;
      next_rel     = 1'b0;
      next_save    = 1'b0;
      next_restore = 1'b0;
      next_src     = move_src;
      next_dst     = move_dst;
      next_soff    = src_offset;
      next_doff    = dst_offset;
      next_cyc     = 2'h1;
      next_bankld  = 1'b0;
      next_mode    = TP_NONE;
      if (pending && w[15:12] == NIB_SECOND) begin
         next_cyc = 2'h2;
         next_fmt = fmt_q;
         unique case (fmt_q)
            F_MOVFF: next_dst = w[11:0];
            F_LFSR:  next_lit = {8'h00, first_word[3:0], w[7:0]};
            F_JUMP: begin
               next_lit = {w[11:0], first_word[7:0]};
               next_br  = {w[11:0], first_word[7:0]};
            end
            F_IDX: begin
               if (first_word[7])
                  next_doff = w[6:0];
               else
                  next_dst = w[11:0];
            end
            default: next_fmt = F_OTHER;
         endcase
      end else begin
         next_err = pending;
         unique case (w[15:12])
            NIB_SECOND: next_fmt = F_NOP;
            NIB_MOVFF: begin
               next_fmt  = F_MOVFF;
               next_src  = w[11:0];
               next_pend = 1'b1;
            end
            NIB_LONG: begin
               if (w[11:8] == SUB_LFSR) begin
                  next_fmt  = F_LFSR;
                  next_pend = 1'b1;
               end else if (w[11:8] == SUB_GOTO || w[11:9] == SUB_CALL) begin
                  next_fmt  = F_JUMP;
                  next_save = (w[11:9] == SUB_CALL) && w[8];
                  next_pend = 1'b1;
               end else if (w[11:8] == SUB_INDEX) begin
                  next_fmt  = F_IDX;
                  next_soff = w[6:0];
                  next_pend = 1'b1;
               end else if (!w[11]) begin
                  next_fmt = F_REL;
                  next_rel = 1'b1;
                  next_br  = sext(w[10:0], 1'b0);
               end
            end
            NIB_BRA: begin
               next_fmt = F_REL;
               next_rel = 1'b1;
               next_br  = sext(w[10:0], 1'b1);
               next_cyc = 2'h2;
            end
            NIB_CTRL: begin
               if (w[11]) begin
                  next_fmt = F_LIT;
                  next_lit = {12'h000, w[7:0]};
               end else if (w[15:8] == HI_BANKLD) begin
                  next_fmt    = F_LIT;
                  next_lit    = {12'h000, w[7:0]};
                  next_bankld = 1'b1;
               end else if (w[15:8] == HI_CTRL && w[7:3] == LO_TBL) begin
                  next_fmt  = F_TBL;
                  next_mode = ood_tpmode_e'(w[1:0]);
                  next_cyc  = 2'h2;
               end else if (w[15:8] == HI_CTRL && w[7:1] == LO_RET) begin
                  next_fmt     = F_RET;
                  next_restore = w[0];
                  next_cyc     = 2'h2;
               end else if (w[15:8] != HI_CTRL) begin
                  next_fmt    = F_BYTE;
                  next_tofile = w[9];
                  next_addr   = file_addr(w[7:0], w[8], bank_selector_register);
               end
            end
            default: begin
               next_fmt    = (w[15:12] >= NIB_BIT0 && w[15:12] < NIB_MOVFF) ? F_BIT : F_BYTE;
               next_tofile = (w[15:12] == NIB_NOD) || w[9];
               next_addr   = file_addr(w[7:0], w[8], bank_selector_register);
            end
         endcase
      end
      if (next_pend)
         next_cyc = 2'h2;
   end

   // Avalon slave handshake
   always_ff @(posedge core_clk) begin
      if (srst)
         avs_waitrequest <= 1'b1;
      else
         avs_waitrequest <= !accept;
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         avs_readdata <= 32'h00000000;
      end else if (accept && avs_read) begin
         unique case (avs_address)
            OFF_INSTR:  avs_readdata <= {16'h0000, word_q};
            OFF_BANK:   avs_readdata <= {28'h0000000, bank_selector_register};
            OFF_TPTR:   avs_readdata <= {11'h000, table_pointer};
            OFF_TBLLAT: avs_readdata <= {24'h000000, table_latch};
            OFF_STATUS: avs_readdata <= {26'h0000000, pair_err, pending, 4'(fmt_q)};
            default:    avs_readdata <= 32'h00000000;
         endcase
      end
   end

   // Bank selector: software write or bank-load instruction
   always_ff @(posedge core_clk) begin
      if (srst)
         bank_selector_register <= BANK_RST;
      else if (accept && instr_wr && next_bankld)
         bank_selector_register <= w[BANK_W-1:0];
      else if (accept && avs_write && avs_address == OFF_BANK && avs_byteenable[0])
         bank_selector_register <= avs_writedata[BANK_W-1:0];
   end

   // Table pointer and latch
   always_ff @(posedge core_clk) begin
      if (srst) begin
         table_pointer <= TP_RST;
         table_address <= TP_RST;
         table_latch   <= TL_RST;
      end else if (accept && instr_wr && next_fmt == F_TBL && !pending) begin
         unique case (next_mode)
            TP_NONE:    table_address <= table_pointer;
            TP_POSTINC: begin
               table_address <= table_pointer;
               table_pointer <= table_pointer + 21'h1;
            end
            TP_POSTDEC: begin
               table_address <= table_pointer;
               table_pointer <= table_pointer - 21'h1;
            end
            TP_PREINC: begin
               table_address <= table_pointer + 21'h1;
               table_pointer <= table_pointer + 21'h1;
            end
         endcase
      end else if (accept && avs_write && avs_address == OFF_TPTR) begin
         table_pointer <= avs_writedata[TP_W-1:0];
      end else if (accept && avs_write && avs_address == OFF_TBLLAT && avs_byteenable[0]) begin
         table_latch <= avs_writedata[TL_W-1:0];
      end
   end

   // Decode results, updated once per instruction cycle
   always_ff @(posedge core_clk) begin
      if (srst) begin
         dec_strobe      <= 1'b0;
         fmt_q           <= F_NOP;
         word_q          <= 16'h0000;
         first_word      <= 16'h0000;
         pending         <= 1'b0;
         data_address    <= 12'h000;
         result_to_file  <= 1'b0;
         bit_select      <= 8'h00;
         pointer_select  <= 2'h0;
         literal_value   <= 20'h00000;
         branch_value    <= 20'h00000;
         branch_relative <= 1'b0;
         shadow_save     <= 1'b0;
         shadow_restore  <= 1'b0;
         move_src        <= 12'h000;
         move_dst        <= 12'h000;
         src_offset      <= 7'h00;
         dst_offset      <= 7'h00;
         exec_cycles     <= 2'h0;
      end else begin
         dec_strobe <= accept && instr_wr;
         if (accept && instr_wr) begin
            fmt_q           <= next_fmt;
            word_q          <= w;
            pending         <= next_pend;
            data_address    <= next_addr;
            result_to_file  <= next_tofile;
            bit_select      <= (next_fmt == F_BIT) ? 8'h01 << w[11:9] : 8'h00;
            // Designator lives in the first word only; the second word carries literal bits there
            pointer_select  <= (next_fmt == F_LFSR && next_pend) ? w[5:4] : pointer_select;
            literal_value   <= next_lit;
            branch_value    <= next_br;
            branch_relative <= next_rel;
            shadow_save     <= next_save;
            shadow_restore  <= next_restore;
            move_src        <= next_src;
            move_dst        <= next_dst;
            src_offset      <= next_soff;
            dst_offset      <= next_doff;
            exec_cycles     <= next_cyc;
            if (next_pend)
               first_word <= w;
         end
      end
   end

   // Broken word pair, sticky; write 1 clears, a new error wins
   always_ff @(posedge core_clk) begin
      if (srst)
         pair_err <= 1'b0;
      else if (accept && instr_wr && next_err)
         pair_err <= 1'b1;
      else if (accept && avs_write && avs_address == OFF_STATUS && avs_writedata[ST_PAIRERR])
         pair_err <= 1'b0;
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);

   AST_ACCESS_RAM: assert property (
      dec_strobe && (fmt_q == F_BYTE || fmt_q == F_BIT) && !word_q[8]
      |-> data_address == {(word_q[7] ? ACC_HI_BANK : 4'h0), word_q[7:0]})
      else $error("access RAM address wrong");
   AST_BANKED: assert property (
      dec_strobe && (fmt_q == F_BYTE || fmt_q == F_BIT) && word_q[8]
      |-> data_address == {$past(bank_selector_register), word_q[7:0]})
      else $error("banked address wrong");
   AST_DEST: assert property (
      dec_strobe && fmt_q == F_BYTE && word_q[15:12] != NIB_NOD |-> result_to_file == word_q[9])
      else $error("destination select wrong");
   AST_BITSEL: assert property (
      dec_strobe && fmt_q == F_BIT |-> $onehot(bit_select) && bit_select[word_q[11:9]])
      else $error("bit select wrong");
   AST_ICYC: assert property (
      dec_strobe |-> $past(phase) == 2'(OSC_PER_ICYC - 1) ##1 !dec_strobe [*3])
      else $error("decode not on instruction cycle");
   AST_LONE_SECOND: assert property (
      dec_strobe && !$past(pending) && word_q[15:12] == NIB_SECOND
      |-> fmt_q == F_NOP && !shadow_save && !shadow_restore && exec_cycles == 2'h1)
      else $error("lone second word not a no-op");
   AST_SHADOW: assert property (
      dec_strobe && fmt_q == F_RET |-> shadow_restore == word_q[0] && !shadow_save)
      else $error("fast return shadow wrong");
   AST_TBL_POSTINC: assert property (
      dec_strobe && fmt_q == F_TBL && word_q[1:0] == 2'h1
      |-> table_pointer == table_address + 21'h1 && table_address == $past(table_pointer))
      else $error("post-increment wrong");
   AST_REL: assert property (
      dec_strobe && fmt_q == F_REL |-> branch_relative && branch_value[19] == word_q[word_q[12] ? 10 : 7])
      else $error("relative offset sign wrong");
   AST_JUMP: assert property (
      dec_strobe && fmt_q == F_JUMP && $past(pending)
      |-> literal_value == {word_q[11:0], first_word[7:0]} && branch_value == literal_value)
      else $error("20-bit literal wrong");
endmodule

// ### hw/ood_pkg.sv
package ood_pkg;
   // Register byte offsets
   localparam int         ADDR_W     = 5;
   localparam logic [4:0] OFF_INSTR  = 5'h00;
   localparam logic [4:0] OFF_BANK   = 5'h04;
   localparam logic [4:0] OFF_TPTR   = 5'h08;
   localparam logic [4:0] OFF_TBLLAT = 5'h0c;
   localparam logic [4:0] OFF_STATUS = 5'h10;
   // Status fields
   localparam int ST_FMT_LSB = 0;
   localparam int ST_PEND    = 4;
   localparam int ST_PAIRERR = 5;
   // Widths
   localparam int BANK_W = 4;
   localparam int TP_W   = 21;
   localparam int TL_W   = 8;
   // Reset values
   localparam logic [3:0]  BANK_RST = 4'h0;
   localparam logic [20:0] TP_RST   = 21'h000000;
   localparam logic [7:0]  TL_RST   = 8'h00;
   // Oscillator periods per instruction cycle
   localparam int OSC_PER_ICYC = 4;
   // Opcode nibbles and patterns
   localparam logic [3:0] NIB_SECOND = 4'hf;
   localparam logic [3:0] NIB_MOVFF  = 4'hc;
   localparam logic [3:0] NIB_LONG   = 4'he;
   localparam logic [3:0] NIB_BRA    = 4'hd;
   localparam logic [3:0] NIB_CTRL   = 4'h0;
   localparam logic [3:0] NIB_NOD    = 4'h6;
   localparam logic [3:0] NIB_BIT0   = 4'h7;
   localparam logic [3:0] SUB_LFSR   = 4'he;
   localparam logic [3:0] SUB_GOTO   = 4'hf;
   localparam logic [3:0] SUB_INDEX  = 4'hb;
   localparam logic [2:0] SUB_CALL   = 3'h6;
   localparam logic [7:0] HI_CTRL    = 8'h00;
   localparam logic [7:0] HI_BANKLD  = 8'h01;
   localparam logic [4:0] LO_TBL     = 5'h01;
   localparam logic [6:0] LO_RET     = 7'h08;
   localparam logic [3:0] ACC_HI_BANK = 4'hf;
   // Pointer update modes
   typedef enum logic [1:0] {TP_NONE, TP_POSTINC, TP_POSTDEC, TP_PREINC} ood_tpmode_e;
   // Decoded instruction formats
   typedef enum logic [3:0] {F_NOP, F_BYTE, F_BIT, F_LIT, F_MOVFF, F_LFSR, F_JUMP,
                             F_REL, F_TBL, F_RET, F_IDX, F_OTHER} ood_fmt_e;
endpackage

// ### sim/ood_prog_mem.sv
`timescale 1ns/1ps
// Instruction stream handed to the decoder, in the order the bench walks it
module ood_prog_mem (
   input  wire logic [5:0]  fetch_addr,
   output logic      [15:0] fetch_word
);
   // Unused positions are zero, apart from one lone second word with ones in them
   localparam logic [15:0] PROGRAM [0:37] = '{
      16'h2434, 16'h269a, 16'h2734, 16'h7012, 16'h7212, 16'h7412, 16'h7612, 16'h7812,
      16'h7a12, 16'h7c12, 16'h7e12, 16'hc123, 16'hfabc, 16'hf555, 16'hc111, 16'h2434,
      16'hee2a, 16'hf0bc, 16'h0e7f, 16'hef12, 16'hf345, 16'hed34, 16'hf001, 16'hec34,
      16'hf001, 16'h0011, 16'h0010, 16'hd7ff, 16'he280, 16'h0008, 16'h0009, 16'h000a,
      16'h000b, 16'h0009, 16'heb85, 16'hf07a, 16'h0107, 16'h2734};
   assign fetch_word = PROGRAM[fetch_addr];
endmodule

// ### sim/opcode_operand_field_decoder_tb_top.sv
`timescale 1ns/1ps
module opcode_operand_field_decoder_tb_top
   import ood_pkg::*;
;
   logic        core_clk = 1'b0;
   logic        srst = 1'b1;
   logic [4:0]  avs_address = 5'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  avs_byteenable = 4'hf;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest, dec_strobe, result_to_file, branch_relative, shadow_save, shadow_restore;
   logic [11:0] data_address, move_src, move_dst;
   logic [7:0]  bit_select;
   logic [1:0]  pointer_select, exec_cycles;
   logic [19:0] literal_value, branch_value;
   logic [6:0]  src_offset, dst_offset;
   logic [20:0] table_address;
   logic [5:0]  fetch_addr = 6'h00;
   logic [15:0] fetch_word;
   logic [3:0]  be = 4'hf;
   logic [31:0] st;
   int          failures = 0;
   int          num_checks = 0;
   int          pc = 0;

   ood_decoder DUT (
      .core_clk(core_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .dec_strobe(dec_strobe),
      .data_address(data_address), .result_to_file(result_to_file), .bit_select(bit_select),
      .pointer_select(pointer_select), .literal_value(literal_value), .branch_value(branch_value),
      .branch_relative(branch_relative), .shadow_save(shadow_save), .shadow_restore(shadow_restore),
      .move_src(move_src), .move_dst(move_dst), .src_offset(src_offset), .dst_offset(dst_offset),
      .table_address(table_address), .exec_cycles(exec_cycles)
   );

   ood_prog_mem prog (
      .fetch_addr(fetch_addr),
      .fetch_word(fetch_word)
   );

   always #4 core_clk = ~core_clk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Request held until waitrequest is sampled low, then released
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge core_clk);
      avs_address    <= a;
      avs_writedata  <= d;
      avs_byteenable <= be;
      avs_write      <= wr;
      avs_read       <= ~wr;
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 40);
      if (avs_waitrequest !== 1'b0) begin
         failures++;
         $display("wrong value at %0t: bus request not answered", $time);
      end
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask

   // Next program word into the instruction register; outputs land with the strobe
   task automatic issue;
      logic [31:0] q;
      fetch_addr = 6'(pc);
      #1;
      bus(1'b1, OFF_INSTR, {16'h0, fetch_word}, q);
      // Strobe stands only in the cycle before the edge at which waitrequest is seen low
      chk(32'(dec_strobe), 32'h1);
      pc++;
      #1;
   endtask

   task automatic tend(input string s);
      $display("test %s finished", s);
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge core_clk);
      failures++;
      results;
   end

   initial begin
      repeat (6) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      chk(32'(avs_waitrequest), 32'h1);
      rd(OFF_BANK, 32'h0);
      rd(OFF_TPTR, 32'h0);
      rd(OFF_TBLLAT, 32'h0);
      rd(5'h14, 32'h0);
      wr(OFF_BANK, 32'h5);
      rd(OFF_BANK, 32'h5);
      tend("reset and registers");
      issue;
      chk(32'(data_address), 32'h034);
      chk(32'(result_to_file), 32'h0);
      chk(32'(exec_cycles), 32'h1);
      issue;
      chk(32'(data_address), 32'hf9a);
      chk(32'(result_to_file), 32'h1);
      issue;
      chk(32'(data_address), 32'h534);
      for (int b = 0; b < 8; b++) begin
         issue;
         chk(32'(bit_select), 32'h1 << b);
      end
      chk(32'(data_address), 32'h012);
      tend("file operands");
      issue;
      bus(1'b0, OFF_STATUS, 32'h0, st);
      chk(32'(st[ST_PEND]), 32'h1);
      issue;
      chk(32'(move_src), 32'h123);
      chk(32'(move_dst), 32'habc);
      chk(32'(exec_cycles), 32'h2);
      issue;
      bus(1'b0, OFF_STATUS, 32'h0, st);
      chk(32'(st[3:0]), 32'(F_NOP));
      chk(32'(data_address), 32'h012);
      issue;
      issue;
      bus(1'b0, OFF_STATUS, 32'h0, st);
      chk(32'(st[ST_PAIRERR]), 32'h1);
      chk(32'(data_address), 32'h034);
      wr(OFF_STATUS, 32'h20);
      bus(1'b0, OFF_STATUS, 32'h0, st);
      chk(32'(st[ST_PAIRERR]), 32'h0);
      tend("two-word pairing");
      issue;
      issue;
      chk(32'(pointer_select), 32'h2);
      chk(32'(literal_value), 32'habc);
      issue;
      chk(32'(literal_value), 32'h7f);
      issue;
      issue;
      chk(32'(branch_value), 32'h34512);
      chk(32'(branch_relative), 32'h0);
      chk(32'(literal_value), 32'h34512);
      issue;
      chk(32'(shadow_save), 32'h1);
      issue;
      chk(32'(branch_value), 32'h00134);
      issue;
      chk(32'(shadow_save), 32'h0);
      issue;
      issue;
      chk(32'(shadow_restore), 32'h1);
      issue;
      chk(32'(shadow_restore), 32'h0);
      issue;
      chk(32'(branch_value), 32'hfffff);
      chk(32'(branch_relative), 32'h1);
      chk(32'(exec_cycles), 32'h2);
      issue;
      chk(32'(branch_value), 32'hfff80);
      tend("literals and control");
      wr(OFF_TPTR, 32'h100);
      for (int m = 0; m < 4; m++) begin
         issue;
         chk(32'(table_address), 32'h100 + 32'(m >> 1));
         rd(OFF_TPTR, 32'h100 + 32'(m % 2));
      end
      wr(OFF_TPTR, 32'h1fffff);
      issue;
      chk(32'(table_address), 32'h1fffff);
      rd(OFF_TPTR, 32'h0);
      wr(OFF_TBLLAT, 32'h1ab);
      rd(OFF_TBLLAT, 32'hab);
      tend("table pointer");
      issue;
      issue;
      chk(32'(src_offset), 32'h05);
      chk(32'(dst_offset), 32'h7a);
      issue;
      rd(OFF_BANK, 32'h7);
      be = 4'h0;
      wr(OFF_BANK, 32'h9);
      be = 4'hf;
      rd(OFF_BANK, 32'h7);
      issue;
      chk(32'(data_address), 32'h734);
      tend("indexed and bank");
      results;
   end
endmodule
